//--- core/flash_host_pkg.sv
// Purpose: constants for the flash status-polling host controller
// Assumes: 250 MHz system clock, 16-bit flash data bus, 22-bit word address
// Notes: register map, command codes, status layout and pin timing
//
// Operation
// - host combines sector and busy toggle flags to learn sector and mode.
// - host reads status twice in a row and compares toggle flag values.
// - toggling with timeout flag high: recheck; still toggling means fail, issue reset.
// - host resuming monitoring restarts the toggle check from its first step.
// - after timeout host issues reset; device returns to read mode.
// - host with sector command gaps under 50 us may skip window checks.
// - host checks window flag before and after each added sector command.
// - host supplies a valid address of the monitored operation when polling.
// - host addresses the busy bank; idle banks return array data.

package flash_host_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int T_ACC_NS = 55;
  localparam int T_WP_NS = 28;
  localparam int T_REC_NS = 20;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int REC_CYC = (T_REC_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // widths
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;

  // ==========================================================================
  // register map
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_RST = 22'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // ==========================================================================
  // command field and codes
  localparam int CMD_ABORT_BIT = 8;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_POLL = 3'h3;
  localparam logic [2:0] OP_RESET = 3'h4;
  localparam logic [2:0] OP_WINDOW = 3'h5;
  localparam logic [DATA_W-1:0] RESET_CMD_DATA = 16'h00F0;

  // ==========================================================================
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_PASS = 2;
  localparam int ST_FAIL = 3;
  localparam int ST_SECT_TGL = 4;
  localparam int ST_BUSY_TGL = 5;
  localparam int ST_WINDOW = 6;
  localparam int ST_TIMEOUT = 7;
  localparam int ST_READY = 8;
  localparam int ST_SUSPENDED = 9;

  // ==========================================================================
  // status positions on the flash data bus
  localparam int DQ_SECT_TGL = 2;
  localparam int DQ_WINDOW = 3;
  localparam int DQ_TIMEOUT = 5;
  localparam int DQ_BUSY_TGL = 6;

endpackage : flash_host_pkg

//--- core/flash_cycle.sv
// Purpose: one asynchronous read or write cycle on the flash pins
// Assumes: data input synchronous to the clock
// Notes: all pin outputs come from flip-flops
`timescale 1ns/100ps
`default_nettype none

module flash_cycle (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request
  input wire logic start,
  input wire logic wr,
  input wire logic [21:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  output logic done,
  // flash pins
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [21:0] a,
  output logic [15:0] dq_o,
  output logic dq_oe,
  input wire logic [15:0] dq_i
);

  typedef enum {CY_IDLE, CY_SETUP, CY_STROBE, CY_REC} cy_state_t;

  cy_state_t cy_q;
  logic [4:0] cnt_q;
  logic wr_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cy_q <= CY_IDLE;
      cnt_q <= 5'h00;
      wr_q <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      a <= 22'h000000;
      dq_o <= 16'h0000;
      dq_oe <= 1'b0;
      rdata <= 16'h0000;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (cy_q)
        CY_IDLE:
          if (start)
          begin
            a <= addr;
            dq_o <= wdata;
            dq_oe <= wr;
            wr_q <= wr;
            ce_n <= 1'b0;
            cy_q <= CY_SETUP;
          end
        CY_SETUP:
        begin
          if (wr_q)
          begin
            we_n <= 1'b0;
            cnt_q <= 5'(flash_host_pkg::WP_CYC - 1);
          end
          else
          begin
            oe_n <= 1'b0;
            cnt_q <= 5'(flash_host_pkg::ACC_CYC - 1);
          end
          cy_q <= CY_STROBE;
        end
        CY_STROBE:
          if (cnt_q == 5'h00)
          begin
            we_n <= 1'b1;
            oe_n <= 1'b1;
            if (!wr_q)
            begin
              rdata <= dq_i;
            end
            cnt_q <= 5'(flash_host_pkg::REC_CYC - 1);
            cy_q <= CY_REC;
          end
          else
          begin
            cnt_q <= cnt_q - 5'h01;
          end
        default:
        begin
          ce_n <= 1'b1;
          dq_oe <= 1'b0;
          if (cnt_q == 5'h00)
          begin
            done <= 1'b1;
            cy_q <= CY_IDLE;
          end
          else
          begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
      endcase
    end
  end

  // write strobe width exact
  property p_we_width;
    @(posedge clk) disable iff (rst)
      $fell(we_n) |-> (!we_n) [*7] ##1 we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

  // output enable held for the access time before data is taken
  property p_oe_width;
    @(posedge clk) disable iff (rst)
      $fell(oe_n) |-> ##13 (!oe_n && we_n) ##1 oe_n;
  endproperty
  a_oe_width: assert property (p_oe_width) else $error("read strobe width wrong");

endmodule : flash_cycle

`default_nettype wire

//--- core/status_compare.sv
// Purpose: compare two successive status reads
// Assumes: load pulses with the second read word present
// Notes: results registered, valid the cycle after load
`timescale 1ns/100ps
`default_nettype none

module status_compare (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // samples
  input wire logic load,
  input wire logic [15:0] first,
  input wire logic [15:0] second,
  // results
  output logic busy_tgl,
  output logic sect_tgl,
  output logic timeout,
  output logic window
);

  function automatic logic bit_changed(input logic [15:0] x, input logic [15:0] y, input int pos);
    bit_changed = x[pos] ^ y[pos];
  endfunction : bit_changed

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_tgl <= 1'b0;
      sect_tgl <= 1'b0;
      timeout <= 1'b0;
      window <= 1'b0;
    end
    else if (load)
    begin
      busy_tgl <= bit_changed(first, second, flash_host_pkg::DQ_BUSY_TGL);
      sect_tgl <= bit_changed(first, second, flash_host_pkg::DQ_SECT_TGL);
      timeout <= second[flash_host_pkg::DQ_TIMEOUT];
      window <= second[flash_host_pkg::DQ_WINDOW];
    end
  end

  property p_cmp;
    @(posedge clk) disable iff (rst)
      load |=> (busy_tgl == ($past(first[6]) ^ $past(second[6])))
        && (sect_tgl == ($past(first[2]) ^ $past(second[2])));
  endproperty
  a_cmp: assert property (p_cmp) else $error("toggle compare wrong");

endmodule : status_compare

`default_nettype wire

//--- core/flash_host.sv
// Purpose: host controller polling flash write-operation status
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes: software builds command sequences with single writes
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module flash_host (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // flash pins
  output logic FLASH_CE_N,
  output logic FLASH_OE_N,
  output logic FLASH_WE_N,
  output logic [21:0] FLASH_A,
  output logic [15:0] FLASH_DQ_O,
  output logic FLASH_DQ_OE,
  input wire logic [15:0] FLASH_DQ_I,
  input wire logic FLASH_RDY_BSY
);

  typedef enum {M_IDLE, M_SINGLE, M_RD_A, M_RD_B, M_EVAL, M_RD_C, M_RD_D, M_EVAL2,
    M_FINAL, M_RESET} main_state_t;

  main_state_t state_q;
  logic [2:0] op_q;
  logic [21:0] addr_q;
  logic [15:0] wdata_q, rdata_q, first_q, cyc_wdata_q, cyc_rdata;
  logic cyc_start_q, cyc_wr_q, issued_q, abort_q, wr_pend_q;
  logic done_q, pass_q, fail_q, win_q, rdy_q;
  logic [7:0] wr_addr_q;
  logic [1:0] pass_reads_q;
  logic cyc_done, cmp_load, bt_tgl, st_tgl, to_flag;
  logic busy, cmd_wr, cmd_go, polling;
  logic [31:0] status_word;

  // ==========================================================================
  // register read decode
  function automatic logic [31:0] reg_read(input logic [7:0] ofs, input logic [31:0] st,
    input logic [21:0] ad, input logic [15:0] wd, input logic [15:0] rd);
    if (ofs == flash_host_pkg::OFS_ADDR)
      reg_read = {10'h000, ad};
    else if (ofs == flash_host_pkg::OFS_WDATA)
      reg_read = {16'h0000, wd};
    else if (ofs == flash_host_pkg::OFS_RDATA)
      reg_read = {16'h0000, rd};
    else if (ofs == flash_host_pkg::OFS_STATUS)
      reg_read = st;
    else
      reg_read = 32'h00000000;
  endfunction : reg_read

  assign busy = (state_q != M_IDLE);
  assign polling = (state_q == M_RD_A) || (state_q == M_RD_B) || (state_q == M_RD_C)
    || (state_q == M_RD_D);
  assign cmd_wr = wr_pend_q && (wr_addr_q == flash_host_pkg::OFS_CMD);
  assign cmd_go = cmd_wr && !busy && (HWDATA[2:0] >= flash_host_pkg::OP_WRITE)
    && (HWDATA[2:0] <= flash_host_pkg::OP_WINDOW);
  assign cmp_load = cyc_done && ((state_q == M_RD_B) || (state_q == M_RD_D));
  // suspended: sector still toggling, busy flag quiet
  assign status_word = {22'h000000, !bt_tgl && st_tgl, rdy_q, to_flag, win_q, bt_tgl, st_tgl,
    fail_q, pass_q, done_q, busy};

  // ==========================================================================
  // ahb-lite slave
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b0;
      HRESP <= 1'b0;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      wr_pend_q <= HSEL && HTRANS[1] && HREADY && HWRITE;
      if (HSEL && HTRANS[1] && HREADY)
      begin
        wr_addr_q <= HADDR[7:0];
        if (!HWRITE)
        begin
          HRDATA <= reg_read(HADDR[7:0], status_word, addr_q, wdata_q, rdata_q);
        end
      end
    end
  end

  // address and data registers, frozen while an operation runs
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      addr_q <= flash_host_pkg::ADDR_RST;
      wdata_q <= flash_host_pkg::DATA_RST;
      op_q <= 3'h0;
    end
    else if (wr_pend_q && !busy)
    begin
      if (wr_addr_q == flash_host_pkg::OFS_ADDR)
        addr_q <= HWDATA[21:0];
      else if (wr_addr_q == flash_host_pkg::OFS_WDATA)
        wdata_q <= HWDATA[15:0];
      else if (cmd_go)
        op_q <= HWDATA[2:0];
    end
  end

  // abort request, honoured only while polling, at the next poll read boundary or status decision
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
      abort_q <= 1'b0;
    else if (cmd_wr && busy && HWDATA[flash_host_pkg::CMD_ABORT_BIT])
      abort_q <= 1'b1;
    else if (!busy)
      abort_q <= 1'b0;
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
      rdy_q <= 1'b0;
    else
      rdy_q <= FLASH_RDY_BSY;
  end

  // ==========================================================================
  // sequencer
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      state_q <= M_IDLE;
      cyc_start_q <= 1'b0;
      cyc_wr_q <= 1'b0;
      cyc_wdata_q <= 16'h0000;
      issued_q <= 1'b0;
      first_q <= 16'h0000;
    end
    else
    begin
      cyc_start_q <= 1'b0;
      case (state_q)
        M_IDLE:
          if (cmd_go)
          begin
            issued_q <= 1'b0;
            if (HWDATA[2:0] == flash_host_pkg::OP_POLL)
              state_q <= M_RD_A;
            else if (HWDATA[2:0] == flash_host_pkg::OP_RESET)
              state_q <= M_RESET;
            else
              state_q <= M_SINGLE;
          end
        M_EVAL:
          if (!bt_tgl)
            state_q <= M_FINAL;
          else if (to_flag)
            state_q <= M_RD_C;
          else if (abort_q)
            state_q <= M_IDLE;
          else
            state_q <= M_RD_A;
        M_EVAL2:
          state_q <= bt_tgl ? M_RESET : M_FINAL;
        default:
          if (!issued_q)
          begin
            cyc_start_q <= 1'b1;
            issued_q <= 1'b1;
            cyc_wr_q <= (state_q == M_RESET) || (op_q == flash_host_pkg::OP_WRITE
              && state_q == M_SINGLE);
            cyc_wdata_q <= (state_q == M_RESET) ? flash_host_pkg::RESET_CMD_DATA : wdata_q;
          end
          else if (cyc_done)
          begin
            issued_q <= 1'b0;
            if (state_q == M_RD_A || state_q == M_RD_C)
              first_q <= cyc_rdata;
            if (polling && abort_q)
              state_q <= M_IDLE;
            else if (state_q == M_RD_A)
              state_q <= M_RD_B;
            else if (state_q == M_RD_B)
              state_q <= M_EVAL;
            else if (state_q == M_RD_C)
              state_q <= M_RD_D;
            else if (state_q == M_RD_D)
              state_q <= M_EVAL2;
            else
              state_q <= M_IDLE;
          end
      endcase
    end
  end

  // ==========================================================================
  // results
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      done_q <= 1'b0;
      pass_q <= 1'b0;
      fail_q <= 1'b0;
      win_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else if (cmd_go)
    begin
      done_q <= 1'b0;
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end
    else if (cyc_done)
    begin
      if (state_q == M_FINAL)
      begin
        rdata_q <= cyc_rdata;
        pass_q <= 1'b1;
        done_q <= 1'b1;
      end
      else if (state_q == M_RESET)
      begin
        fail_q <= (op_q == flash_host_pkg::OP_POLL);
        done_q <= 1'b1;
      end
      else if (state_q == M_SINGLE)
      begin
        rdata_q <= cyc_rdata;
        done_q <= 1'b1;
        if (op_q == flash_host_pkg::OP_WINDOW)
          win_q <= cyc_rdata[flash_host_pkg::DQ_WINDOW];
      end
    end
  end

  // pass-local read count for checking
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
      pass_reads_q <= 2'h0;
    else if (state_q == M_IDLE || state_q == M_EVAL)
      pass_reads_q <= 2'h0;
    else if (cyc_done && (state_q == M_RD_A || state_q == M_RD_B) && pass_reads_q != 2'h3)
      pass_reads_q <= pass_reads_q + 2'h1;
  end

  // ==========================================================================
  // submodules
  flash_cycle u_cycle (
    .clk(CLK_SYS),
    .rst(RESET),
    .start(cyc_start_q),
    .wr(cyc_wr_q),
    .addr(addr_q),
    .wdata(cyc_wdata_q),
    .rdata(cyc_rdata),
    .done(cyc_done),
    .ce_n(FLASH_CE_N),
    .oe_n(FLASH_OE_N),
    .we_n(FLASH_WE_N),
    .a(FLASH_A),
    .dq_o(FLASH_DQ_O),
    .dq_oe(FLASH_DQ_OE),
    .dq_i(FLASH_DQ_I)
  );

  status_compare u_cmp (
    .clk(CLK_SYS),
    .rst(RESET),
    .load(cmp_load),
    .first(first_q),
    .second(cyc_rdata),
    .busy_tgl(bt_tgl),
    .sect_tgl(st_tgl),
    .timeout(to_flag),
    .window()
  );

  // ==========================================================================
  // checks
  property p_two_reads;
    @(posedge CLK_SYS) disable iff (RESET)
      $rose(state_q == M_EVAL) |-> pass_reads_q == 2'h2;
  endproperty
  a_two_reads: assert property (p_two_reads) else $error("decision before two reads");

  property p_fail_reset;
    @(posedge CLK_SYS) disable iff (RESET)
      $rose(fail_q) |-> $past(state_q == M_RESET) && $past(cyc_wdata_q) == 16'h00F0;
  endproperty
  a_fail_reset: assert property (p_fail_reset) else $error("fail without reset write");

  property p_pass_final;
    @(posedge CLK_SYS) disable iff (RESET)
      $rose(pass_q) |-> $past(state_q == M_FINAL) && rdata_q == $past(cyc_rdata);
  endproperty
  a_pass_final: assert property (p_pass_final) else $error("pass without array read");

  property p_poll_addr;
    @(posedge CLK_SYS) disable iff (RESET)
      polling && !FLASH_CE_N |-> FLASH_A == addr_q && !FLASH_DQ_OE;
  endproperty
  a_poll_addr: assert property (p_poll_addr) else $error("poll at wrong address");

  property p_restart;
    @(posedge CLK_SYS) disable iff (RESET)
      cmd_go && HWDATA[2:0] == 3'h3 |=> state_q == M_RD_A ##1 state_q == M_RD_A;
  endproperty
  a_restart: assert property (p_restart) else $error("poll not restarted at top");

  property p_window;
    @(posedge CLK_SYS) disable iff (RESET)
      cyc_done && state_q == M_SINGLE && op_q == 3'h5 |=> win_q == $past(cyc_rdata[3]) && !busy;
  endproperty
  a_window: assert property (p_window) else $error("window flag not captured");

endmodule : flash_host

`default_nettype wire

//--- bench/flash_model.sv
// Purpose: behavioural flash device answering status reads
// Assumes: one busy bank, ready/busy pulled up
// Notes: cfg inputs steer the running operation
`timescale 1ns/100ps
`default_nettype none

module flash_model #(
  parameter logic [15:0] ARR = 16'hA513
) (
  // flash pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  output logic [15:0] dq_i,
  output logic rdy_bsy,
  // behaviour controls
  input wire logic [15:0] cfg_reads,
  input wire logic cfg_tmo,
  input wire logic cfg_win,
  input wire logic cfg_susp
);
  logic busy = 1'b0;
  logic t6 = 1'b0;
  logic t2 = 1'b0;
  logic [15:0] pd = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic [15:0] left = 16'h0000;
  logic [15:0] word;

  // status while busy, array data otherwise
  assign word = busy ? {8'h00, ~pd[7], t6, cfg_tmo, 1'b0, cfg_win, t2, 2'h0} : ARR;
  // released bus shows the inverse of the last word
  assign dq_i = dq_oe ? dq_o : (!ce_n && !oe_n) ? word : ~last;
  assign rdy_bsy = !(busy && !cfg_susp);

  always @(posedge oe_n)
    if (!ce_n)
    begin
      last = word;
      if (busy)
      begin
        t6 = cfg_susp ? t6 : ~t6;
        t2 = ~t2;
        left = left - 16'h0001;
        busy = (left != 16'h0000);
      end
    end

  always @(posedge we_n)
    if (!ce_n && dq_oe)
    begin
      if (dq_o == 16'h00F0)
        busy = 1'b0;
      else if (!busy)
      begin
        pd = dq_o;
        left = cfg_reads;
        busy = 1'b1;
      end
    end
endmodule : flash_model

`default_nettype wire

//--- bench/tb_top.sv
// Purpose: self-checking bench for the flash status-polling host
// Assumes: zero wait AHB-Lite slave, behavioural flash model
// Notes: each scenario is one task
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, ce_n, oe_n, we_n, dq_oe, rdy;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [21:0] fa;
  logic [15:0] dq_o, dq_i, cfg_reads;
  logic cfg_tmo, cfg_win, cfg_susp;
  int n_fail, checks;

  flash_host dut_u (.CLK_SYS(clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n),
    .FLASH_WE_N(we_n), .FLASH_A(fa), .FLASH_DQ_O(dq_o), .FLASH_DQ_OE(dq_oe),
    .FLASH_DQ_I(dq_i), .FLASH_RDY_BSY(rdy));

  flash_model flash_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_o(dq_o), .dq_oe(dq_oe),
    .dq_i(dq_i), .rdy_bsy(rdy), .cfg_reads(cfg_reads), .cfg_tmo(cfg_tmo), .cfg_win(cfg_win),
    .cfg_susp(cfg_susp));

  // ==========================================================================
  // bus tasks
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask : ahb

  task cmd(input logic [31:0] c, input logic wt);
    int i;
    ahb(1'b1, flash_host_pkg::OFS_CMD, c);
    ahb(1'b0, flash_host_pkg::OFS_CMD, 32'h0);
    for (i = 0; i < 600 && wt; i++)
    begin
      ahb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
      if (r[flash_host_pkg::ST_BUSY] === 1'b0)
        break;
    end
    chk("cmd done", {31'h0, i < 600}, 32'h00000001);
  endtask : cmd

  task start_op(input logic [15:0] d);
    ahb(1'b1, flash_host_pkg::OFS_ADDR, 32'h00000100);
    ahb(1'b1, flash_host_pkg::OFS_WDATA, {16'h0000, d});
    cmd({29'h0, flash_host_pkg::OP_WRITE}, 1'b1);
  endtask : start_op

  task poll_st(input string nm, input logic [31:0] m, input logic [31:0] e);
    cmd({29'h0, flash_host_pkg::OP_POLL}, 1'b1);
    chk(nm, r & m, e);
  endtask : poll_st

  // ==========================================================================
  // scenarios
  task t_regs;
    ahb(1'b0, flash_host_pkg::OFS_ADDR, 32'h0);
    chk("addr reset", r, 32'h0);
    ahb(1'b0, flash_host_pkg::OFS_WDATA, 32'h0);
    chk("wdata reset", r, 32'h0);
    ahb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    chk("status reset", r & 32'h0000030F, 32'h00000100);
    chk("hresp", {31'h0, hresp}, 32'h0);
    ahb(1'b1, flash_host_pkg::OFS_ADDR, 32'hFFFFFFFF);
    ahb(1'b0, flash_host_pkg::OFS_ADDR, 32'h0);
    chk("addr width", r, 32'h003FFFFF);
    ahb(1'b1, 8'h20, 32'hFFFFFFFF);
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", r, 32'h0);
  endtask : t_regs

  task t_poll_ok;
    cfg_reads <= 16'h0003;
    start_op(16'h1234);
    chk("busy pin", r & 32'h00000100, 32'h0);
    poll_st("poll pass", 32'h0000018F, 32'h00000106);
    ahb(1'b0, flash_host_pkg::OFS_RDATA, 32'h0);
    chk("array data", r, 32'h0000A513);
    chk("flash addr", {10'h000, fa}, 32'h00000100);
  endtask : t_poll_ok

  task t_poll_fail;
    cfg_tmo <= 1'b1;
    cfg_reads <= 16'h03E8;
    start_op(16'h0081);
    poll_st("poll fail", 32'h0000018F, 32'h0000018A);
    cfg_reads <= 16'h0002;
    start_op(16'h0000);
    poll_st("late stop", 32'h0000018F, 32'h00000106);
    cfg_tmo <= 1'b0;
  endtask : t_poll_fail

  task t_window;
    cfg_reads <= 16'h03E8;
    cfg_win <= 1'b1;
    start_op(16'h0055);
    cmd({29'h0, flash_host_pkg::OP_WINDOW}, 1'b1);
    chk("window one", r & 32'h00000140, 32'h00000040);
    cfg_win <= 1'b0;
    cmd({29'h0, flash_host_pkg::OP_WINDOW}, 1'b1);
    chk("window zero", r & 32'h00000140, 32'h0);
    cmd({29'h0, flash_host_pkg::OP_RESET}, 1'b1);
    ahb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    chk("reset ready", r & 32'h00000100, 32'h00000100);
  endtask : t_window

  task t_abort;
    start_op(16'h0066);
    cmd({29'h0, flash_host_pkg::OP_POLL}, 1'b0);
    ahb(1'b1, flash_host_pkg::OFS_ADDR, 32'h00000ABC);
    cmd(32'h00000100, 1'b1);
    chk("abort idle", r & 32'h00000001, 32'h0);
    ahb(1'b0, flash_host_pkg::OFS_ADDR, 32'h0);
    chk("busy refuse", r, 32'h00000100);
    cmd({29'h0, flash_host_pkg::OP_RESET}, 1'b1);
  endtask : t_abort

  task t_suspend;
    cfg_susp <= 1'b1;
    start_op(16'h0077);
    poll_st("suspended", 32'h000003BF, 32'h00000316);
    ahb(1'b0, flash_host_pkg::OFS_RDATA, 32'h0);
    chk("polling bit", r & 32'h00000080, 32'h00000080);
    cfg_susp <= 1'b0;
    cmd({29'h0, flash_host_pkg::OP_RESET}, 1'b1);
    cmd({29'h0, flash_host_pkg::OP_READ}, 1'b1);
    ahb(1'b0, flash_host_pkg::OFS_RDATA, 32'h0);
    chk("read op", r, 32'h0000A513);
  endtask : t_suspend

  task finish_test;
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // ==========================================================================
  // clock, run and watchdog
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cfg_reads = 16'h0003;
    cfg_tmo = 1'b0;
    cfg_win = 1'b0;
    cfg_susp = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs;
    t_poll_ok;
    t_poll_fail;
    t_window;
    t_abort;
    t_suspend;
    finish_test;
  end

  initial
  begin
    #300000;
    n_fail++;
    finish_test;
  end
endmodule : tb_top

`default_nettype wire
